/* verif/fehdlc_line_model.sv */
// framer line model: offers slots and loops the tx stream back
module fehdlc_line_model (
   input wire logic clk_i, // core clock
   input wire logic srst_i, // sync reset
   input wire logic tx_data_i, // bit from controller
   input wire logic tx_vld_i, // bit valid
   output logic tx_slot_o, // slot offer
   output logic [2:0] idx_o, // bit position
   output logic rx_slot_o, // rx bit strobe
   output logic rx_data_o // rx bit
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [1:0] div_q; // a slot every fourth cycle, like a slow line
   // =====================================================
   // the looped bit is offered back one cycle after it leaves
   always @(posedge clk_i) begin
      if (srst_i) begin
         {div_q, tx_slot_o, idx_o, rx_slot_o, rx_data_o} <= '0;
      end else begin
         div_q <= div_q + 2'h1;
         tx_slot_o <= (div_q == 2'h3);
         if (tx_slot_o) begin
            idx_o <= idx_o + 3'h1;
         end
         rx_slot_o <= tx_vld_i;
         // between bits the line is not held: show the inverse
         rx_data_o <= tx_vld_i ? tx_data_i : !rx_data_o;
      end
   end
endmodule // fehdlc_line_model

/* verif/fehdlc_top_assertions.sv */
// port-level checks of the embedded hdlc controller
module fehdlc_chk (
   input wire logic core_clk_i, // core clock
   input wire logic srst_i, // sync reset
   input wire logic [4:0] avs_address_i, // byte address
   input wire logic avs_read_i, // read request
   input wire logic avs_write_i, // write request
   input wire logic avs_waitrequest_o, // stall
   input wire logic tx_slot_i, // tx slot offer
   input wire logic tx_data_o, // tx bit
   input wire logic tx_data_vld_o, // tx bit valid
   input wire logic [4:0] tx_chan_o, // tx timeslot
   input wire logic e1_mode_o, // e1 select
   input wire logic irq_o // interrupt
);
   default clocking cb @(posedge core_clk_i); endclocking
   default disable iff (srst_i);
   // =====================================================
   // bus handshake: one wait state on a read
   sequence s_rd_answer;
      avs_waitrequest_o ##1 !avs_waitrequest_o;
   endsequence
   a_read_one_wait: assert property (avs_read_i && !$past(avs_read_i) |-> s_rd_answer)
      else $error("read wait state wrong");
   a_wait_cause: assert property (avs_waitrequest_o |-> avs_read_i || avs_write_i && avs_address_i == 5'h0c)
      else $error("stall without cause");
   a_write_free: assert property (avs_write_i && avs_address_i != 5'h0c |-> !avs_waitrequest_o)
      else $error("write stalled");
   // =====================================================
   // line side: a bit leaves only one cycle after a slot
   a_vld_cause: assert property (tx_data_vld_o |-> $past(tx_slot_i))
      else $error("tx valid without slot");
   a_bit_hold: assert property (!$past(tx_slot_i) |-> $stable(tx_data_o) && !tx_data_vld_o)
      else $error("tx bit moved between slots");
   a_reset_quiet: assert property ($fell(srst_i) |-> tx_data_o && !tx_data_vld_o && !irq_o && tx_chan_o == 5'h00)
      else $error("outputs not at reset level");
   a_reset_mode: assert property ($fell(srst_i) |-> !e1_mode_o)
      else $error("e1 mode set out of reset");
   // sticky events: interrupt only falls after a register write
   a_irq_sticky: assert property ($fell(irq_o) |-> $past(avs_write_i, 2))
      else $error("interrupt dropped by itself");
endmodule // fehdlc_chk
bind fehdlc_top fehdlc_chk chk_u (.core_clk_i(core_clk_i), .srst_i(srst_i), .avs_address_i(avs_address_i),
   .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_waitrequest_o(avs_waitrequest_o),
   .tx_slot_i(tx_slot_i), .tx_data_o(tx_data_o), .tx_data_vld_o(tx_data_vld_o), .tx_chan_o(tx_chan_o),
   .e1_mode_o(e1_mode_o), .irq_o(irq_o));

/* verif/fehdlc_top_tb.sv */
// register-level test of the embedded hdlc controller
`include "fehdlc_regs.svh"
module fehdlc_top_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk = 1'b0, rst = 1'b1, rd = 1'b0, wr = 1'b0, ws, txs, txd, txv, rxs, rxd, irq;
   logic [4:0] adr = 5'h00;
   logic [31:0] wd = 32'h0, rdat, v;
   logic [2:0] idx;
   int errors = 0, checked = 0;
   always #12.5 clk = !clk;
   fehdlc_top dut_u (.core_clk_i(clk), .srst_i(rst), .avs_address_i(adr), .avs_read_i(rd), .avs_write_i(wr),
      .avs_writedata_i(wd), .avs_byteenable_i(4'hf), .avs_readdata_o(rdat), .avs_waitrequest_o(ws),
      .tx_slot_i(txs), .tx_slot_idx_i(idx), .tx_data_o(txd), .tx_data_vld_o(txv), .rx_slot_i(rxs),
      .rx_slot_idx_i(idx), .rx_data_i(rxd), .tx_chan_o(), .rx_chan_o(), .tx_dl_sel_o(), .rx_dl_sel_o(),
      .e1_mode_o(), .sa4_crc_upd_o(), .irq_o(irq));
   fehdlc_line_model line_u (.clk_i(clk), .srst_i(rst), .tx_data_i(txd), .tx_vld_i(txv), .tx_slot_o(txs),
      .idx_o(idx), .rx_slot_o(rxs), .rx_data_o(rxd));
   // =====================================================
   // bus tasks: hold the request until waitrequest is low
   task automatic acc(input logic w, input logic [4:0] a, input logic [31:0] d);
      @(posedge clk);
      {wr, rd, adr, wd} <= {w, !w, a, d};
      do @(posedge clk); while (ws !== 1'b0);
      v = rdat;
      {wr, rd} <= 2'b00;
   endtask
   task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
      checked++;
      if (s !== e) begin
         errors++;
         $display("BAD %s expected %h seen %h", n, e, s);
      end
   endtask
   function automatic logic [15:0] crcb(input logic [15:0] c, input logic [7:0] b);
      for (int i = 0; i < 8; i++) c = (c[0] ^ b[i]) ? (c >> 1) ^ 16'h8408 : c >> 1;
      return c;
   endfunction
   task automatic complete_run;
      $display("checks %0d mismatches %0d", checked, errors);
      if (errors == 0 && checked > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   // watchdog: the whole run needs a few hundred cycles
   initial begin
      repeat (20000) @(posedge clk);
      errors++;
      complete_run;
   end
   // =====================================================
   initial begin
      logic [15:0] f;
      f = ~crcb(crcb(16'hffff, 8'hff), 8'h3e);
      repeat (10) @(posedge clk);
      rst <= 0;
      acc(0, `FEHDLC_RATE, 0);
      chk("rate", v, 32'h0000_ffff);
      acc(0, `FEHDLC_CTRL, 0);
      chk("ctrl", v, 32'h0);
      $display("test reset done");
      // a one byte frame (24 bits) then a two byte one with stuffing
      acc(1, `FEHDLC_MASK, 32'h20);
      acc(1, `FEHDLC_CTRL, 32'h3);
      acc(1, `FEHDLC_TXDATA, 32'h181);
      acc(1, `FEHDLC_TXDATA, 32'hff);
      acc(1, `FEHDLC_TXDATA, 32'h13e);
      for (int i = 0; i < 600 && !v[5]; i++) acc(0, `FEHDLC_STAT, 0);
      chk("rx eop", {31'h0, v[5]}, 32'h1);
      chk("irq", {31'h0, irq}, 32'h1);
      acc(0, `FEHDLC_RXDATA, 0);
      chk("rx0", v, 32'hff);
      acc(0, `FEHDLC_RXDATA, 0);
      chk("rx1", v, 32'h3e);
      acc(0, `FEHDLC_RXDATA, 0);
      chk("fcs lo", v, {24'h0, f[7:0]});
      acc(0, `FEHDLC_RXDATA, 0);
      chk("fcs hi", v, {24'h1, f[15:8]});
      acc(0, `FEHDLC_RXDATA, 0);
      chk("empty", {31'h0, v[31]}, 32'h1);
      acc(0, `FEHDLC_RXFCS, 0);
      chk("rxfcs", {16'h0, v[15:0]}, {16'h0, f});
      $display("test frame done");
      acc(1, `FEHDLC_STAT, 32'h7f);
      repeat (2) @(posedge clk);
      chk("irq clr", {31'h0, irq}, 32'h0);
      $display("test irq done");
      complete_run;
   end
endmodule // fehdlc_top_tb

/* verilog/fehdlc_pkg.sv */
// types shared by the embedded hdlc controller
package fehdlc_pkg;
   // transmit unit sequencer
   typedef enum logic [2:0] {
      TS_IDLE = 3'b000,
      TS_DATA = 3'b001,
      TS_FCSL = 3'b010,
      TS_FCSH = 3'b011,
      TS_CLOSE = 3'b100
   } fehdlc_txst_t;
endpackage : fehdlc_pkg

/* verilog/fehdlc_regs.svh */
// register map, field positions, reset values and line constants of the embedded hdlc controller
// Operation
// - flags, fcs and zero stuffing both directions
// - idle fill is flags or all ones
// - abort on command and on tx underrun
// - fcs mismatch marks frame as bad
// - frames under 25 bits are dropped silently
// - frames of 25 to 31 bits are bad
// - aborted frame data kept, interrupt raised
// - received fcs bytes visible to software
// - fcs append can be switched off
// - one-byte, two-byte and all-call address match
// - independent 32 byte tx and rx fifos
// - rx nearly-full and overflow maskable interrupts
// - tx nearly-empty and underflow maskable interrupts
// - tx and rx end-of-packet maskable interrupts
// - bad frame interrupt, aborts included
// - tx-to-rx and rx-to-tx loopbacks
// - per direction enable and bit-rate setting
// - t1 fdl 4k or channel 56k/64k
// - e1 sa4-sa8 bits or full timeslot
// - crc-4 remainder follows sa4 data link
`ifndef FEHDLC_REGS_SVH
`define FEHDLC_REGS_SVH
// =====================================================
// register offsets (byte addresses)
`define FEHDLC_CTRL 5'h00
`define FEHDLC_RATE 5'h04
`define FEHDLC_ADDR 5'h08
`define FEHDLC_TXDATA 5'h0c
`define FEHDLC_RXDATA 5'h10
`define FEHDLC_STAT 5'h14
`define FEHDLC_MASK 5'h18
`define FEHDLC_RXFCS 5'h1c
// =====================================================
// control fields
`define FEHDLC_C_TXEN 0
`define FEHDLC_C_RXEN 1
`define FEHDLC_C_IDLE1 2
`define FEHDLC_C_NOFCS 3
`define FEHDLC_C_ABORT 4
`define FEHDLC_C_TXLB 5
`define FEHDLC_C_RXLB 6
`define FEHDLC_C_AMODE 8
`define FEHDLC_C_E1 10
`define FEHDLC_C_SA4CRC 11
`define FEHDLC_C_TXDL 12
`define FEHDLC_C_RXDL 13
`define FEHDLC_CTRL_RST 32'h0000_0000
`define FEHDLC_RATE_RST 32'h0000_ffff
`define FEHDLC_ADDR_RST 32'h0000_0000
`define FEHDLC_MASK_RST 7'h00
// status event bits
`define FEHDLC_S_RXNF 0
`define FEHDLC_S_RXOVF 1
`define FEHDLC_S_TXNE 2
`define FEHDLC_S_TXUDF 3
`define FEHDLC_S_TXEOP 4
`define FEHDLC_S_RXEOP 5
`define FEHDLC_S_RXBAD 6
// fifo entry flag bits
`define FEHDLC_F_EOP 8
`define FEHDLC_F_BAD 9
`define FEHDLC_F_ABT 10
`define FEHDLC_RX_EMPTY 31
// =====================================================
// fifo levels and line constants
`define FEHDLC_DEPTH 6'd32
`define FEHDLC_RX_NFULL 6'd28
`define FEHDLC_TX_NEMPTY 6'd4
`define FEHDLC_FLAG 8'h7e
`define FEHDLC_ABT_SEQ 8'hfe
`define FEHDLC_ONES 8'hff
`define FEHDLC_CRC_INIT 16'hffff
`define FEHDLC_CRC_POLY 16'h8408
`define FEHDLC_CRC_GOOD 16'hf0b8
`define FEHDLC_MIN_BITS 6'd25
`define FEHDLC_OK_BITS 6'd32
`endif

/* verilog/fehdlc_top.sv */
// embedded hdlc controller: avalon registers, fifos, transmit framer and receive deframer
//
// Our own choices: the address map and the Avalon-MM interface to the registers.
`include "fehdlc_regs.svh"
module fehdlc_top (
   input wire logic core_clk_i, // 40 mhz core clock
   input wire logic srst_i, // synchronous reset, active high
   input wire logic [4:0] avs_address_i, // byte address
   input wire logic avs_read_i, // read request
   input wire logic avs_write_i, // write request
   input wire logic [31:0] avs_writedata_i, // write data
   input wire logic [3:0] avs_byteenable_i, // byte lanes
   output logic [31:0] avs_readdata_o, // read data, registered
   output logic avs_waitrequest_o, // stall
   input wire logic tx_slot_i, // framer offers a transmit bit slot
   input wire logic [2:0] tx_slot_idx_i, // bit position inside slot
   output logic tx_data_o, // transmit bit
   output logic tx_data_vld_o, // transmit bit valid pulse
   input wire logic rx_slot_i, // framer delivers a receive bit
   input wire logic [2:0] rx_slot_idx_i, // bit position inside slot
   input wire logic rx_data_i, // receive bit
   output logic [4:0] tx_chan_o, // assigned transmit timeslot
   output logic [4:0] rx_chan_o, // assigned receive timeslot
   output logic tx_dl_sel_o, // transmit uses fdl or sa bits
   output logic rx_dl_sel_o, // receive uses fdl or sa bits
   output logic e1_mode_o, // e1 assignment rules apply
   output logic sa4_crc_upd_o, // recompute crc-4 over sa4 link
   output logic irq_o // combined masked interrupt
);
   // =====================================================
   // helpers
   // one bit of the reflected crc-16
   function automatic logic [15:0] crc_step(input logic [15:0] c, input logic b);
      crc_step = (c[0] ^ b) ? ((c >> 1) ^ `FEHDLC_CRC_POLY) : (c >> 1);
   endfunction
   // merge write data by byte enables
   function automatic logic [31:0] be_merge(input logic [31:0] o, input logic [31:0] n,
                                            input logic [3:0] be);
      be_merge = o;
      for (int i = 0; i < 4; i++) begin
         if (be[i]) begin
            be_merge[i*8 +: 8] = n[i*8 +: 8];
         end
      end
   endfunction

   // =====================================================
   // registers
   logic [31:0] ctrl_q; // control
   logic [31:0] rate_q; // slot masks and channel numbers
   logic [31:0] addr_q; // station address bytes
   logic [6:0] mask_q; // interrupt mask
   logic [6:0] stat_q; // sticky events
   logic [15:0] rxfcs_q; // last received check sequence
   logic abort_pend_q; // software abort waiting for a byte boundary
   logic rd_done_q; // second cycle of a read
   logic [6:0] ev; // events this cycle
   // fifo storage and pointers
   logic [8:0] tx_mem [0:31]; // byte plus end marker
   logic [10:0] rx_mem [0:31]; // byte plus eop, bad, abort
   logic [5:0] tx_wr_q, tx_rd_q; // tx pointers with wrap bit
   logic [5:0] rx_wr_q, rx_rd_q, rx_cm_q; // rx pointers, cm = committed end
   logic tx_ne_lvl_q, rx_nf_lvl_q; // previous level for edge events

   wire [5:0] tx_cnt = tx_wr_q - tx_rd_q;
   wire [5:0] rx_cnt = rx_wr_q - rx_rd_q;
   wire [5:0] rx_vis = rx_cm_q - rx_rd_q; // only whole frames are readable
   wire tx_full = (tx_cnt == `FEHDLC_DEPTH);
   wire tx_empty = (tx_cnt == 6'd0);
   wire rx_full = (rx_cnt == `FEHDLC_DEPTH);
   wire [8:0] tx_head = tx_mem[tx_rd_q[4:0]];
   wire [10:0] rx_head = rx_mem[rx_rd_q[4:0]];

   // =====================================================
   // bus decode
   wire sel_txd = (avs_address_i == `FEHDLC_TXDATA);
   wire sel_rxd = (avs_address_i == `FEHDLC_RXDATA);
   wire rd_first = avs_read_i & ~rd_done_q;
   // reads take one wait state so that read data comes from flip-flops;
   // a tx data write stalls while the fifo is full, which is the back-pressure
   assign avs_waitrequest_o = rd_first | (avs_write_i & sel_txd & tx_full);
   wire wr_acc = avs_write_i & ~avs_waitrequest_o;
   wire tx_push = wr_acc & sel_txd;
   // pop only when the word handed out held a real entry
   wire rx_pop = rd_done_q & avs_read_i & sel_rxd & ~avs_readdata_o[`FEHDLC_RX_EMPTY];
   logic [31:0] rd_mux;
   always_comb begin
      case (avs_address_i)
         `FEHDLC_CTRL: rd_mux = ctrl_q;
         `FEHDLC_RATE: rd_mux = rate_q;
         `FEHDLC_ADDR: rd_mux = addr_q;
         `FEHDLC_RXDATA: rd_mux = (rx_vis != 6'd0) ? {21'h0, rx_head} : 32'h8000_0000;
         `FEHDLC_STAT: rd_mux = {2'h0, rx_cnt, 2'h0, tx_cnt, 9'h0, stat_q};
         `FEHDLC_MASK: rd_mux = {25'h0, mask_q};
         `FEHDLC_RXFCS: rd_mux = {16'h0, rxfcs_q};
         default: rd_mux = 32'h0; // unmapped and write-only read as zero
      endcase
   end

   // register writes; the abort bit is a command and never stays set
   always_ff @(posedge core_clk_i) begin
      if (srst_i) begin
         ctrl_q <= `FEHDLC_CTRL_RST;
         rate_q <= `FEHDLC_RATE_RST;
         addr_q <= `FEHDLC_ADDR_RST;
         mask_q <= `FEHDLC_MASK_RST;
      end else if (wr_acc) begin
         if (avs_address_i == `FEHDLC_CTRL) begin
            ctrl_q <= be_merge(ctrl_q, avs_writedata_i, avs_byteenable_i) & 32'hffff_ffef;
         end
         if (avs_address_i == `FEHDLC_RATE) begin
            rate_q <= be_merge(rate_q, avs_writedata_i, avs_byteenable_i);
         end
         if (avs_address_i == `FEHDLC_ADDR) begin
            addr_q <= be_merge(addr_q, avs_writedata_i, avs_byteenable_i);
         end
         if (avs_address_i == `FEHDLC_MASK && avs_byteenable_i[0]) begin
            mask_q <= avs_writedata_i[6:0];
         end
      end
   end

   // read pipeline
   always_ff @(posedge core_clk_i) begin
      if (srst_i) begin
         rd_done_q <= 1'b0;
         avs_readdata_o <= 32'h0;
      end else begin
         rd_done_q <= rd_first;
         if (rd_first) begin
            avs_readdata_o <= rd_mux;
         end
      end
   end

   // sticky status, write one to clear; a new event wins over the clear
   wire [6:0] st_clr = (wr_acc && avs_address_i == `FEHDLC_STAT && avs_byteenable_i[0]) ?
                       avs_writedata_i[6:0] : 7'h0;
   always_ff @(posedge core_clk_i) begin
      if (srst_i) begin
         stat_q <= 7'h0;
         irq_o <= 1'b0;
      end else begin
         stat_q <= (stat_q & ~st_clr) | ev;
         irq_o <= |(stat_q & mask_q);
      end
   end

   // line assignment outputs straight from the registers
   assign tx_chan_o = rate_q[20:16];
   assign rx_chan_o = rate_q[28:24];
   assign tx_dl_sel_o = ctrl_q[`FEHDLC_C_TXDL];
   assign rx_dl_sel_o = ctrl_q[`FEHDLC_C_RXDL];
   assign e1_mode_o = ctrl_q[`FEHDLC_C_E1];
   assign sa4_crc_upd_o = ctrl_q[`FEHDLC_C_SA4CRC];

   // =====================================================
   // transmit
   wire tx_en = ctrl_q[`FEHDLC_C_TXEN];
   wire rx_en = ctrl_q[`FEHDLC_C_RXEN];
   wire txlb = ctrl_q[`FEHDLC_C_TXLB];
   wire rxlb = ctrl_q[`FEHDLC_C_RXLB];
   // the slot mask picks the bits of a slot: ff 64k, 7f 56k, one bit fdl, sa4..sa8
   wire tx_hit = tx_slot_i & rate_q[tx_slot_idx_i];
   wire rx_hit = rx_slot_i & rate_q[{1'b1, rx_slot_idx_i}];
   wire tx_go = tx_hit & tx_en & ~rxlb;
   fehdlc_pkg::fehdlc_txst_t ts_q, ts_d; // unit sequencer
   logic [7:0] tsh_q; // bits of current unit left to send
   logic [3:0] tcnt_q; // count of those bits
   logic tstf_q, tcrc_on_q; // current unit is stuffed / enters crc
   logic [2:0] tones_q; // consecutive ones sent in stuffed content
   logic [15:0] tcrc_q; // running crc
   logic tbit_q, tvld_q; // line output
   logic [7:0] u; // unit chosen at a load
   logic u_stf, u_crc, u_pop, u_abt_clr, u_udf, u_eop;
   wire stuff_now = tstf_q & (tones_q == 3'd5);
   wire ld = (tcnt_q == 4'd0) & ~stuff_now;

   // next unit: decided at byte boundaries only
   always_comb begin
      u = `FEHDLC_FLAG;
      u_stf = 1'b0;
      u_crc = 1'b0;
      u_pop = 1'b0;
      u_abt_clr = 1'b0;
      u_udf = 1'b0;
      u_eop = 1'b0;
      ts_d = ts_q;
      case (ts_q)
         fehdlc_pkg::TS_IDLE: begin
            u_abt_clr = 1'b1; // an abort outside a frame has nothing to cut
            if (!tx_empty) begin
               ts_d = fehdlc_pkg::TS_DATA; // opening flag
            end else if (ctrl_q[`FEHDLC_C_IDLE1]) begin
               u = `FEHDLC_ONES;
            end
         end
         fehdlc_pkg::TS_DATA: begin
            if (abort_pend_q || tx_empty) begin
               u = `FEHDLC_ABT_SEQ;
               u_abt_clr = 1'b1;
               u_udf = ~abort_pend_q;
               ts_d = fehdlc_pkg::TS_IDLE;
            end else begin
               u = tx_head[7:0];
               u_stf = 1'b1;
               u_crc = 1'b1;
               u_pop = 1'b1;
               if (tx_head[8]) begin
                  ts_d = ctrl_q[`FEHDLC_C_NOFCS] ? fehdlc_pkg::TS_CLOSE : fehdlc_pkg::TS_FCSL;
               end
            end
         end
         fehdlc_pkg::TS_FCSL: begin
            u = ~tcrc_q[7:0];
            u_stf = 1'b1;
            ts_d = fehdlc_pkg::TS_FCSH;
         end
         fehdlc_pkg::TS_FCSH: begin
            u = ~tcrc_q[15:8];
            u_stf = 1'b1;
            ts_d = fehdlc_pkg::TS_CLOSE;
         end
         fehdlc_pkg::TS_CLOSE: begin
            u_eop = 1'b1; // closing flag
            ts_d = fehdlc_pkg::TS_IDLE;
         end
         default: ts_d = fehdlc_pkg::TS_IDLE;
      endcase
   end

   wire t_pop = tx_go & ld & u_pop;
   // bit placed on the line this slot
   wire t_bit = stuff_now ? 1'b0 : (ld ? u[0] : tsh_q[0]);
   wire t_stf = ld ? u_stf : tstf_q;
   wire t_crc = ld ? u_crc : tcrc_on_q;

   always_ff @(posedge core_clk_i) begin
      if (srst_i) begin
         ts_q <= fehdlc_pkg::TS_IDLE;
         tsh_q <= 8'h0;
         tcnt_q <= 4'd0;
         tstf_q <= 1'b0;
         tcrc_on_q <= 1'b0;
         tones_q <= 3'd0;
         tcrc_q <= `FEHDLC_CRC_INIT;
      end else if (tx_go) begin
         if (stuff_now) begin
            tones_q <= 3'd0;
         end else begin
            if (ld) begin
               ts_q <= ts_d;
               tsh_q <= {1'b0, u[7:1]};
               tcnt_q <= 4'd7;
               tstf_q <= u_stf;
               tcrc_on_q <= u_crc;
            end else begin
               tsh_q <= {1'b0, tsh_q[7:1]};
               tcnt_q <= tcnt_q - 4'd1;
            end
            tones_q <= (t_stf && t_bit) ? tones_q + 3'd1 : 3'd0;
            if (ld && ts_q == fehdlc_pkg::TS_IDLE) begin
               tcrc_q <= `FEHDLC_CRC_INIT;
            end else if (t_crc) begin
               tcrc_q <= crc_step(tcrc_q, t_bit);
            end
         end
      end
   end

   // abort command waits for the next data byte boundary of a frame; one still pending at idle is cleared unsent
   always_ff @(posedge core_clk_i) begin
      if (srst_i) begin
         abort_pend_q <= 1'b0;
      end else if (wr_acc && avs_address_i == `FEHDLC_CTRL && avs_byteenable_i[0] &&
                   avs_writedata_i[`FEHDLC_C_ABORT]) begin
         abort_pend_q <= 1'b1;
      end else if (tx_go && ld && u_abt_clr) begin
         abort_pend_q <= 1'b0;
      end
   end

   // line output; rx-to-tx loopback turns the receive bits round
   // the bit only moves on a slot, so the framer may sample it any time before the next one
   wire t_slot = rxlb ? rx_hit : tx_hit;
   always_ff @(posedge core_clk_i) begin
      if (srst_i) begin
         tbit_q <= 1'b1;
         tvld_q <= 1'b0;
      end else begin
         tvld_q <= t_slot;
         if (t_slot) begin
            tbit_q <= rxlb ? rx_data_i : (tx_en ? t_bit : 1'b1);
         end
      end
   end
   assign tx_data_o = tbit_q;
   assign tx_data_vld_o = tvld_q;

   // tx fifo
   always_ff @(posedge core_clk_i) begin
      if (srst_i) begin
         tx_wr_q <= 6'd0;
         tx_rd_q <= 6'd0;
      end else begin
         if (tx_push) begin
            tx_wr_q <= tx_wr_q + 6'd1;
         end
         if (t_pop) begin
            tx_rd_q <= tx_rd_q + 6'd1;
         end
      end
   end
   always_ff @(posedge core_clk_i) begin
      if (tx_push) begin
         tx_mem[tx_wr_q[4:0]] <= avs_writedata_i[8:0];
      end
   end

   // =====================================================
   // receive
   // tx-to-rx loopback feeds the deframer from the transmit output
   wire r_v = (txlb ? tvld_q : rx_hit) & rx_en;
   wire r_b = txlb ? tbit_q : rx_data_i;
   logic [2:0] rones_q; // consecutive ones seen
   logic rinf_q; // between an opening flag and its end
   logic [5:0] rdl_q; // six bit delay hides the closing flag
   logic [2:0] rdn_q; // fill of that delay
   logic [7:0] rsh_q; // byte assembly
   logic [2:0] rbn_q; // bits in byte
   logic [5:0] rnb_q; // data bits, saturating
   logic [15:0] rcrc_q, rfcs_q; // crc and last sixteen bits
   logic [1:0] rbc_q; // bytes seen, saturating
   logic rdrop_q, rall_q, rbad_q; // address miss, all-call, overflow

   wire r_flag = r_v & ~r_b & (rones_q == 3'd6);
   wire r_abt = r_v & r_b & (rones_q == 3'd6); // seventh one
   wire r_data = r_v & rinf_q & (r_b ? (rones_q < 3'd5) : (rones_q < 3'd5));
   wire d_out = r_data & (rdn_q == 3'd6);
   wire d_bit = rdl_q[0];
   wire byte_done = d_out & (rbn_q == 3'd7);
   wire [7:0] r_byte = {d_bit, rsh_q[7:1]};
   wire [1:0] amode = ctrl_q[`FEHDLC_C_AMODE +: 2];
   wire addr_miss = (rbc_q == 2'd0) ? (amode != 2'd0 && r_byte != addr_q[7:0] && r_byte != `FEHDLC_ONES) :
                    (rbc_q == 2'd1) ? (amode == 2'd2 && !rall_q && r_byte != addr_q[15:8]) : 1'b0;
   wire r_push = byte_done & ~rdrop_q & ~addr_miss;
   wire in_frame = rinf_q & (rnb_q != 6'd0);
   wire r_end = r_flag & in_frame;
   wire r_cut = r_abt & in_frame;
   wire r_keep = r_end & (rnb_q >= `FEHDLC_MIN_BITS) & ~rdrop_q;
   wire r_bad = (rnb_q < `FEHDLC_OK_BITS) | (rcrc_q != `FEHDLC_CRC_GOOD) | rbad_q | (rbn_q != 3'd0);
   wire r_any = (rx_wr_q != rx_cm_q); // frame has stored bytes
   wire r_mark = (r_keep | (r_cut & ~rdrop_q)) & r_any;

   // deframer state
   always_ff @(posedge core_clk_i) begin
      if (srst_i) begin
         rones_q <= 3'd0;
         rinf_q <= 1'b0;
         rdn_q <= 3'd0;
         rdl_q <= 6'h0;
         rbn_q <= 3'd0;
         rnb_q <= 6'd0;
         rsh_q <= 8'h0;
         rcrc_q <= `FEHDLC_CRC_INIT;
         rfcs_q <= 16'h0;
         rbc_q <= 2'd0;
         rdrop_q <= 1'b0;
         rall_q <= 1'b0;
         rbad_q <= 1'b0;
      end else if (r_v) begin
         rones_q <= r_b ? ((rones_q == 3'd7) ? 3'd7 : rones_q + 3'd1) : 3'd0;
         if (r_flag) begin
            // every flag opens a frame and clears the frame state
            rinf_q <= 1'b1;
            rdn_q <= 3'd0;
            rbn_q <= 3'd0;
            rnb_q <= 6'd0;
            rcrc_q <= `FEHDLC_CRC_INIT;
            rbc_q <= 2'd0;
            rdrop_q <= 1'b0;
            rall_q <= 1'b0;
            rbad_q <= 1'b0;
         end else if (r_abt) begin
            rinf_q <= 1'b0; // wait for the next flag
         end else if (r_data) begin
            rdl_q <= {r_b, rdl_q[5:1]};
            if (rdn_q != 3'd6) begin
               rdn_q <= rdn_q + 3'd1;
            end
            if (d_out) begin
               rsh_q <= r_byte;
               rbn_q <= rbn_q + 3'd1;
               rnb_q <= (rnb_q == 6'd63) ? 6'd63 : rnb_q + 6'd1;
               rcrc_q <= crc_step(rcrc_q, d_bit);
               rfcs_q <= {d_bit, rfcs_q[15:1]};
            end
            if (byte_done) begin
               rbc_q <= (rbc_q == 2'd2) ? 2'd2 : rbc_q + 2'd1;
               if (rbc_q == 2'd0) begin
                  rall_q <= (r_byte == `FEHDLC_ONES);
               end
               if (addr_miss) begin
                  rdrop_q <= 1'b1;
               end
               if (r_push && rx_full) begin
                  rbad_q <= 1'b1;
               end
            end
         end
      end
   end

   // rx fifo: bytes stay hidden until their frame ends, so a short or
   // unaddressed frame is removed by winding the write pointer back
   always_ff @(posedge core_clk_i) begin
      if (srst_i) begin
         rx_wr_q <= 6'd0;
         rx_rd_q <= 6'd0;
         rx_cm_q <= 6'd0;
         rxfcs_q <= 16'h0;
      end else begin
         if (r_push && !rx_full) begin
            rx_wr_q <= rx_wr_q + 6'd1;
         end
         if (r_keep || (r_cut && !rdrop_q)) begin
            rx_cm_q <= rx_wr_q;
         end else if (r_end || r_cut) begin
            rx_wr_q <= rx_cm_q;
         end
         if (r_keep) begin
            rxfcs_q <= rfcs_q;
         end
         if (rx_pop) begin
            rx_rd_q <= rx_rd_q + 6'd1;
         end
      end
   end
   always_ff @(posedge core_clk_i) begin
      if (r_push && !rx_full) begin
         rx_mem[rx_wr_q[4:0]] <= {3'b000, r_byte};
      end else if (r_mark) begin
         rx_mem[rx_wr_q[4:0] - 5'd1][10:8] <= {r_cut, r_cut | r_bad, 1'b1};
      end
   end

   // =====================================================
   // events
   wire tx_ne_lvl = (tx_cnt <= `FEHDLC_TX_NEMPTY);
   wire rx_nf_lvl = (rx_cnt >= `FEHDLC_RX_NFULL);
   always_ff @(posedge core_clk_i) begin
      if (srst_i) begin
         tx_ne_lvl_q <= 1'b1;
         rx_nf_lvl_q <= 1'b0;
      end else begin
         tx_ne_lvl_q <= tx_ne_lvl;
         rx_nf_lvl_q <= rx_nf_lvl;
      end
   end
   always_comb begin
      ev = 7'h0;
      ev[`FEHDLC_S_RXNF] = rx_nf_lvl & ~rx_nf_lvl_q;
      ev[`FEHDLC_S_RXOVF] = r_v & r_push & rx_full;
      ev[`FEHDLC_S_TXNE] = tx_ne_lvl & ~tx_ne_lvl_q;
      ev[`FEHDLC_S_TXUDF] = tx_go & ld & u_udf;
      ev[`FEHDLC_S_TXEOP] = tx_go & ld & u_eop;
      ev[`FEHDLC_S_RXEOP] = r_keep;
      ev[`FEHDLC_S_RXBAD] = (r_keep & r_bad) | r_cut;
   end
endmodule // fehdlc_top
